// file: ebp_pkg.sv
// Constants, register map and carrier types of the bridge PWM unit
`default_nettype none
package ebp_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DUTY   = 8'h04;
    localparam logic [7:0] OFS_SHADOW = 8'h08;
    localparam logic [7:0] OFS_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_DEAD   = 8'h10;
    localparam logic [7:0] OFS_TSEL   = 8'h14;
    localparam logic [7:0] OFS_STAT   = 8'h18;

    // Control register fields
    localparam int CTRL_CFG_HI  = 7;
    localparam int CTRL_CFG_LO  = 6;
    localparam int CTRL_DLSB_HI = 5;
    localparam int CTRL_DLSB_LO = 4;
    localparam int CTRL_MODE_HI = 3;
    localparam int CTRL_MODE_LO = 0;

    // Timer select register fields
    localparam int TSEL_PWM_B  = 0;
    localparam int TSEL_CMP_B  = 1;
    localparam int TSEL_PRE_LO = 2;
    localparam int TSEL_PRE_HI = 3;
    localparam int TSEL_ADC_EN = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DUTY_RST   = 8'h00;
    localparam logic [7:0] PERIOD_RST = 8'h00;
    localparam logic [6:0] DEAD_RST   = 7'h00;
    localparam logic [4:0] TSEL_RST   = 5'h00;

    // Mode codes and output configurations
    localparam logic [3:0] MODE_CMP_SWI  = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [1:0] PWM_MODE_TOP  = 2'b11;
    localparam logic [1:0] CFG_SINGLE    = 2'b00;
    localparam logic [1:0] CFG_FULL_FWD  = 2'b01;
    localparam logic [1:0] CFG_HALF      = 2'b10;
    localparam logic [1:0] CFG_FULL_REV  = 2'b11;

    // Timing: one instruction cycle is four core clocks
    localparam int         TOSC_NS        = 50;
    localparam int         TCY_NS         = 4 * TOSC_NS;
    localparam logic [1:0] QTR_LAST       = 2'((TCY_NS / TOSC_NS) - 1);
    localparam int         TRIG_UNIT_MAX  = 2;
    localparam int         ADC_UNIT       = 2;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } ebp_axi_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } ebp_axi_rsp_s;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic d;
    } ebp_bridge_s;

    typedef struct packed {
        logic [7:0]      ctrl;
        logic [7:0]      duty;
        logic [7:0]      shadow;
        logic [1:0]      shadow_lsb;
        logic [7:0]      period;
        logic [6:0]      dead;
        logic [4:0]      tsel;
        logic [1:0]      cfg_buf;
        logic [1:0]      pol_buf;
        logic [6:0]      dead_buf;
        logic [1:0]      quarter;
        logic [3:0]      presc;
        logic [1:0][7:0] tb;
        logic            raw;
        logic            started;
        logic [6:0]      cnt_a;
        logic [6:0]      cnt_b;
        logic            act_a;
        logic            act_b;
        ebp_bridge_s     pins;
        logic            match_q;
        logic            cmp_event;
        logic [1:0]      timer_rst;
        logic            adc_start;
        logic            flag_inhibit;
        logic            aw_have;
        logic [31:0]     aw_addr;
        logic            w_have;
        logic [7:0]      w_data;
        logic            w_lane0;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } ebp_state_s;

    localparam ebp_state_s STATE_RST = '0;

endpackage : ebp_pkg
`default_nettype wire

// file: ebp_timer_model.sv
// Behavioural model of the two wide timers beside the unit
`timescale 1ns/10ps
`default_nettype none
module ebp_timer_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // Unit side
    input  wire logic [1:0]  reset_in,
    input  wire logic        inhibit_in,
    output var  logic [15:0] timer_a_out,
    output var  logic [15:0] timer_b_out,
    output var  logic [1:0]  flag_out
);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            timer_a_out <= 16'h0000;
            timer_b_out <= 16'h0000;
            flag_out    <= 2'b00;
        end else begin
            timer_a_out <= reset_in[0] ? 16'h0000 : timer_a_out + 16'h0001;
            timer_b_out <= reset_in[1] ? 16'h0000 : timer_b_out + 16'h0001;
            flag_out    <= flag_out | (reset_in & {2{!inhibit_in}});
        end
    end
endmodule : ebp_timer_model
`default_nettype wire

// file: ebp_unit.sv
// Enhanced compare and bridge PWM unit with AXI4-Lite registers
//
// Notes on behaviour
// RQ1 - Mode 1011: compare pair equal to selected wide timer gives trigger pulse.
// RQ2 - Trigger resets the selected 16-bit wide timer, making a programmable period.
// RQ3 - Second unit's trigger also starts a conversion when converter enabled.
// RQ4 - Units three to five treat mode 1011 exactly like mode 1010.
// RQ5 - Second unit's trigger never sets the reset timer's interrupt flag.
// RQ6 - Control bits 7:6 select outputs; bits 3:0 select mode and polarity.
// RQ7 - PWM timebase selectable between two identical 8-bit timers.
// RQ8 - PWM settings buffered, applied only when the timebase resets.
// RQ9 - Dead-band value loaded at duty boundary or period boundary, whichever first.
// RQ10 - Output starts only after the first timebase reset.
// RQ11 - Period is (limit plus 1) times four clocks times prescale.
// RQ12 - After limit match: clear timebase, set output unless duty zero, load shadow.
// RQ13 - No postscaler affects PWM frequency.
// RQ14 - Duty is 10 bits: upper byte register plus control bits 5:4.
// RQ15 - Duty writable anytime; shadow loads at period match, read-only in PWM.
// RQ16 - Output clears when shadow duty equals timebase extended by two bits.
// RQ17 - Duty beyond period never clears output that period.
// RQ18 - Output field picks single, half-bridge, full forward or full reverse.
// RQ19 - Half-bridge: PWM on A, complement on B.
// RQ20 - Half-bridge: each inactive-to-active edge delayed by dead-band cycles.
// RQ21 - Dead band longer than the phase keeps that output inactive.
// RQ22 - Full forward: A on, D modulated; reverse: C on, B modulated.
// RQ23 - Direction change takes effect from the next PWM cycle.
// RQ24 - Dead band held in seven bits, counted in instruction cycles.
// RQ25 - Polarity inversion applied after dead band and steering.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module ebp_unit #(
    parameter int UNIT_INDEX = 2
) (
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_in,
    // Register bus
    input  wire ebp_pkg::ebp_axi_req_s axi_req_in,
    output var  ebp_pkg::ebp_axi_rsp_s axi_rsp_out,
    // Wide timers
    input  wire logic [15:0]          wide_timer_a_in,
    input  wire logic [15:0]          wide_timer_b_in,
    output var  logic [1:0]           wide_timer_reset_out,
    output var  logic                 timer_flag_inhibit_out,
    // Compare events
    output var  logic                 compare_event_out,
    output var  logic                 adc_start_out,
    // Bridge pins
    output var  ebp_pkg::ebp_bridge_s bridge_out
);
    import ebp_pkg::*;

    ebp_state_s s_q;
    ebp_state_s s_d;

    function automatic logic is_pwm(input logic [7:0] ctrl);
        return ctrl[CTRL_MODE_HI:CTRL_MODE_HI-1] == PWM_MODE_TOP;
    endfunction : is_pwm

    function automatic logic reg_known(input logic [31:0] addr);
        logic hit;
        hit = 1'b0;
        if (addr[31:8] == 24'h00_0000) begin
            unique case (addr[7:0])
                OFS_CTRL, OFS_DUTY, OFS_SHADOW, OFS_PERIOD,
                OFS_DEAD, OFS_TSEL, OFS_STAT: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return hit;
    endfunction : reg_known

    function automatic logic [1:0] ext_pick(input logic [1:0] pre, input logic [1:0] q, input logic [3:0] p);
        logic [1:0] e;
        e = p[3:2];
        if (pre == 2'b00) begin
            e = q;
        end else if (pre == 2'b01) begin
            e = p[1:0];
        end
        return e;
    endfunction : ext_pick

    function automatic logic [3:0] pre_mask(input logic [1:0] pre);
        logic [3:0] m;
        m = 4'hF;
        if (pre == 2'b00) begin
            m = 4'h0;
        end else if (pre == 2'b01) begin
            m = 4'h3;
        end
        return m;
    endfunction : pre_mask

    logic        pwm_on;
    logic [1:0]  pre_sel;
    logic        instr_tick;
    logic        tb_tick;
    logic [7:0]  tb_sel;
    logic        period_end;
    logic [1:0]  ext_bits;
    logic [9:0]  duty_next;
    logic [15:0] cmp_val;
    logic        cmp_mode;
    logic        special_hit;
    logic        rise;
    logic        fall;
    ebp_bridge_s steer;

    assign pwm_on     = is_pwm(s_q.ctrl);
    assign pre_sel    = s_q.tsel[TSEL_PRE_HI:TSEL_PRE_LO];
    assign instr_tick = s_q.quarter == QTR_LAST;
    assign tb_tick    = instr_tick && ((s_q.presc & pre_mask(pre_sel)) == pre_mask(pre_sel)); // see RQ11
    assign tb_sel     = s_q.tb[s_q.tsel[TSEL_PWM_B]];                                          // see RQ7
    assign period_end = tb_tick && (tb_sel == s_q.period);
    assign duty_next  = {s_q.duty, s_q.ctrl[CTRL_DLSB_HI:CTRL_DLSB_LO]};                       // see RQ14
    assign cmp_val    = s_q.tsel[TSEL_CMP_B] ? wide_timer_b_in : wide_timer_a_in;
    assign cmp_mode   = (s_q.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_CMP_SWI)
                     || (s_q.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_CMP_TRIG);

    always_comb begin
        s_d = s_q;
        // Free-running quarter clock and prescaler
        s_d.quarter = 2'(s_q.quarter + 2'd1);
        if (instr_tick) begin
            s_d.presc = 4'(s_q.presc + 4'd1);
        end
        // No postscaler sits in the period path
        for (int i = 0; i < 2; i++) begin                                                      // see RQ13
            if (tb_tick) begin
                s_d.tb[i] = (s_q.tb[i] == s_q.period) ? 8'h00 : 8'(s_q.tb[i] + 8'd1);         // see RQ7
            end
        end
        // Count being entered, so duty spans whole clocks
        ext_bits = ext_pick(pre_sel, s_d.quarter, s_d.presc);                                   // see RQ16

        // Duty generation
        if (!pwm_on) begin
            s_d.started = 1'b0;
            s_d.raw     = 1'b0;
        end else if (period_end) begin
            s_d.started    = 1'b1;                                                              // see RQ10
            s_d.shadow     = s_q.duty;                                                          // see RQ12
            s_d.shadow_lsb = s_q.ctrl[CTRL_DLSB_HI:CTRL_DLSB_LO];                               // see RQ15
            s_d.raw        = duty_next != 10'h000;                                              // see RQ12
            s_d.cfg_buf    = s_q.ctrl[CTRL_CFG_HI:CTRL_CFG_LO];                                 // see RQ8
            s_d.pol_buf    = s_q.ctrl[CTRL_MODE_LO+1:CTRL_MODE_LO];                             // see RQ8
            s_d.dead_buf   = s_q.dead;                                                          // see RQ9
        end else if (s_q.started && s_q.raw
                     && ({s_q.shadow, s_q.shadow_lsb} == {s_d.tb[s_q.tsel[TSEL_PWM_B]], ext_bits})) begin
            // Never reached while duty exceeds the period
            s_d.raw      = 1'b0;                                                                // see RQ16, RQ17
            s_d.dead_buf = s_q.dead;                                                            // see RQ9
        end

        // Dead band counters in instruction cycles
        rise = s_d.raw && !s_q.raw;
        fall = !s_d.raw && s_q.raw;
        if (instr_tick && s_q.cnt_a != 7'h00) begin
            s_d.cnt_a = 7'(s_q.cnt_a - 7'd1);                                                   // see RQ24
        end
        if (instr_tick && s_q.cnt_b != 7'h00) begin
            s_d.cnt_b = 7'(s_q.cnt_b - 7'd1);                                                   // see RQ24
        end
        if (rise) begin
            s_d.cnt_a = s_d.dead_buf;                                                           // see RQ20
        end
        if (fall) begin
            s_d.cnt_b = s_d.dead_buf;                                                           // see RQ20
        end
        s_d.act_a = s_d.raw && (s_d.cnt_a == 7'h00);                                            // see RQ21
        s_d.act_b = s_d.started && !s_d.raw && (s_d.cnt_b == 7'h00);                            // see RQ19, RQ21

        // Bridge steering, then polarity
        steer = '0;
        if (s_d.started) begin
            unique case (s_d.cfg_buf)                                                           // see RQ18, RQ23
                CFG_SINGLE: steer.a = s_d.raw;
                CFG_HALF: begin
                    steer.a = s_d.act_a;                                                        // see RQ19, RQ20
                    steer.b = s_d.act_b;
                end
                CFG_FULL_FWD: begin
                    steer.a = 1'b1;                                                             // see RQ22
                    steer.d = s_d.raw;
                end
                CFG_FULL_REV: begin
                    steer.c = 1'b1;                                                             // see RQ22
                    steer.b = s_d.raw;
                end
            endcase
        end
        s_d.pins = '0;
        if (pwm_on) begin
            s_d.pins = steer ^ {s_d.pol_buf[1], s_d.pol_buf[0], s_d.pol_buf[1], s_d.pol_buf[0]}; // see RQ6, RQ25
        end

        // Compare matches and special event trigger
        s_d.match_q   = !pwm_on && cmp_mode && ({s_q.shadow, s_q.duty} == cmp_val);             // see RQ1
        special_hit   = s_d.match_q && !s_q.match_q
                     && (s_q.ctrl[CTRL_MODE_HI:CTRL_MODE_LO] == MODE_CMP_TRIG)
                     && (UNIT_INDEX <= TRIG_UNIT_MAX);                                          // see RQ4
        s_d.cmp_event = s_d.match_q && !s_q.match_q;                                            // see RQ4
        s_d.timer_rst = 2'b00;
        if (special_hit) begin
            s_d.timer_rst = s_q.tsel[TSEL_CMP_B] ? 2'b10 : 2'b01;                               // see RQ2
        end
        s_d.adc_start    = special_hit && (UNIT_INDEX == ADC_UNIT) && s_q.tsel[TSEL_ADC_EN];   // see RQ3
        s_d.flag_inhibit = special_hit && (UNIT_INDEX == ADC_UNIT);                             // see RQ5

        // Bus write path: address and data in either order
        if (axi_req_in.awvalid && !s_q.aw_have && !s_q.bvalid) begin
            s_d.aw_have = 1'b1;
            s_d.aw_addr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && !s_q.w_have && !s_q.bvalid) begin
            s_d.w_have  = 1'b1;
            s_d.w_data  = axi_req_in.wdata[7:0];
            s_d.w_lane0 = axi_req_in.wstrb[0];
        end
        if (s_q.aw_have && s_q.w_have) begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = reg_known(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (s_q.w_lane0 && reg_known(s_q.aw_addr)) begin
                unique case (s_q.aw_addr[7:0])
                    OFS_CTRL:   s_d.ctrl   = s_q.w_data;                                        // see RQ6
                    OFS_DUTY:   s_d.duty   = s_q.w_data;                                        // see RQ15
                    OFS_SHADOW: if (!pwm_on) s_d.shadow = s_q.w_data;                           // see RQ15
                    OFS_PERIOD: s_d.period = s_q.w_data;
                    OFS_DEAD:   s_d.dead   = s_q.w_data[6:0];                                   // see RQ24
                    OFS_TSEL:   s_d.tsel   = s_q.w_data[4:0];                                   // see RQ7
                    default: ;
                endcase
            end
        end else if (s_q.bvalid && axi_req_in.bready) begin
            s_d.bvalid = 1'b0;
        end

        // Bus read path
        if (s_q.rvalid) begin
            if (axi_req_in.rready) begin
                s_d.rvalid = 1'b0;
            end
        end else if (axi_req_in.arvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = reg_known(axi_req_in.araddr) ? RESP_OKAY : RESP_SLVERR;
            s_d.rdata  = 32'h0000_0000;
            if (reg_known(axi_req_in.araddr)) begin
                unique case (axi_req_in.araddr[7:0])
                    OFS_CTRL:   s_d.rdata = {24'h00_0000, s_q.ctrl};
                    OFS_DUTY:   s_d.rdata = {24'h00_0000, s_q.duty};
                    OFS_SHADOW: s_d.rdata = {24'h00_0000, s_q.shadow};
                    OFS_PERIOD: s_d.rdata = {24'h00_0000, s_q.period};
                    OFS_DEAD:   s_d.rdata = {25'h000_0000, s_q.dead};
                    OFS_TSEL:   s_d.rdata = {27'h000_0000, s_q.tsel};
                    OFS_STAT:   s_d.rdata = {19'h0_0000, s_q.started, s_q.pins, tb_sel};
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        axi_rsp_out         = '0;
        axi_rsp_out.awready = !s_q.aw_have && !s_q.bvalid;
        axi_rsp_out.wready  = !s_q.w_have && !s_q.bvalid;
        axi_rsp_out.bvalid  = s_q.bvalid;
        axi_rsp_out.bresp   = s_q.bresp;
        axi_rsp_out.arready = !s_q.rvalid;
        axi_rsp_out.rvalid  = s_q.rvalid;
        axi_rsp_out.rdata   = s_q.rdata;
        axi_rsp_out.rresp   = s_q.rresp;
    end

    assign wide_timer_reset_out   = s_q.timer_rst;
    assign timer_flag_inhibit_out = s_q.flag_inhibit;
    assign compare_event_out      = s_q.cmp_event;
    assign adc_start_out          = s_q.adc_start;
    assign bridge_out             = s_q.pins;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    AST_TRIG_CAUSE: assert property ( // see RQ1
        (wide_timer_reset_out != 2'b00) |-> ($past(s_q.ctrl[3:0]) == MODE_CMP_TRIG) && compare_event_out
    ) else $error("Trigger without a mode 1011 compare match");

    AST_TRIG_TIMER: assert property ( // see RQ2
        (wide_timer_reset_out != 2'b00) |-> (wide_timer_reset_out[1] == $past(s_q.tsel[TSEL_CMP_B]))
    ) else $error("Trigger reset the wrong wide timer");

    AST_ADC_START: assert property ( // see RQ3
        adc_start_out |-> (UNIT_INDEX == ADC_UNIT) && (wide_timer_reset_out != 2'b00) && $past(s_q.tsel[TSEL_ADC_EN])
    ) else $error("Conversion start without enabled trigger");

    AST_NO_TRIG_HIGH: assert property ( // see RQ4
        (UNIT_INDEX > TRIG_UNIT_MAX) |-> (wide_timer_reset_out == 2'b00) && !adc_start_out
    ) else $error("Trigger raised on a unit without one");

    AST_FLAG_BLOCK: assert property ( // see RQ5
        ((wide_timer_reset_out != 2'b00) && (UNIT_INDEX == ADC_UNIT)) |-> timer_flag_inhibit_out
    ) else $error("Timer flag not held off during trigger reset");

    AST_SHADOW_HOLD: assert property ( // see RQ15
        (pwm_on && !period_end) |=> $stable(s_q.shadow) && $stable(s_q.shadow_lsb)
    ) else $error("Shadow duty changed outside a period match");

    AST_PERIOD_SET: assert property ( // see RQ12
        (pwm_on && period_end && (duty_next != 10'h000)) |=> s_q.raw && (tb_sel == 8'h00) && s_q.started
    ) else $error("Period start did not set output and clear timebase");

    AST_FULL_FWD: assert property ( // see RQ22
        (s_q.started && pwm_on && (s_q.cfg_buf == CFG_FULL_FWD) && (s_q.pol_buf == 2'b00))
            |=> ##1 (!is_pwm(s_q.ctrl) || !s_q.started || (s_q.cfg_buf != CFG_FULL_FWD) || (s_q.pol_buf != 2'b00)
                || (bridge_out.a && !bridge_out.b && !bridge_out.c))
    ) else $error("Forward full bridge drives wrong pins");

    AST_DEAD_HOLD: assert property ( // see RQ20
        (s_q.raw && !$past(s_q.raw) && (s_q.cfg_buf == CFG_HALF) && (s_q.cnt_a != 7'h00))
            |-> !s_q.act_a [*2]
    ) else $error("Dead band did not delay output A");

endmodule : ebp_unit
`default_nettype wire

// file: ebp_unit_end.sv
// Intentionally no further logic
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the bridge PWM unit
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module tb_top;
    import ebp_pkg::*;
    logic                clk;
    logic                rst;
    ebp_axi_req_s        req;
    ebp_axi_rsp_s        rsp;
    logic [15:0]         tmr_a;
    logic [15:0]         tmr_b;
    logic [1:0]          tmr_rst;
    logic [1:0]          tmr_flag;
    logic                inhibit;
    logic                cmp_ev;
    logic                adc;
    ebp_bridge_s         pins;
    int                  err_total;
    int                  n_tests;
    int                  cyc;
    logic [31:0]         d;
    logic [1:0]          r;
    int                  hi;
    int                  t0;
    int                  t1;
    ebp_unit #(.UNIT_INDEX(2)) ebp_unit_inst (.core_clk_in(clk), .rst_in(rst), .axi_req_in(req),
        .axi_rsp_out(rsp), .wide_timer_a_in(tmr_a), .wide_timer_b_in(tmr_b), .wide_timer_reset_out(tmr_rst),
        .timer_flag_inhibit_out(inhibit), .compare_event_out(cmp_ev), .adc_start_out(adc), .bridge_out(pins));
    ebp_timer_model ebp_timer_model_inst (.clk_in(clk), .rst_in(rst), .reset_in(tmr_rst),
        .inhibit_in(inhibit), .timer_a_out(tmr_a), .timer_b_out(tmr_b), .flag_out(tmr_flag));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc++;
    task automatic tally_and_finish();
        $display("Comparisons %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic axw(input logic [7:0] a, input logic [7:0] v);
        int n;
        n = 0;
        r = 2'b01;
        @(posedge clk);
        req.awaddr  <= {24'h00_0000, a};
        req.wdata   <= {24'h00_0000, v};
        req.wstrb   <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                n = 99;
            end
        end
        if (n != 99) err_total++;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        int n;
        n = 0;
        r = 2'b01;
        @(posedge clk);
        req.araddr  <= {24'h00_0000, a};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                n = 99;
            end
        end
        if (n != 99) err_total++;
    endtask : axr
    task automatic wait_evt(output int t);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cmp_ev !== 1'b1 && n < 600);
        t = cyc;
    endtask : wait_evt
    function automatic logic lvl(int s, bit inv);
        return pins[3-s] ^ inv;
    endfunction : lvl
    // High time and period of one pin, in clocks
    task automatic pwm_case(input logic [7:0] c, input logic [7:0] du, input logic [6:0] dl, input int s,
                            input bit inv);
        int n;
        int per;
        axw(OFS_DUTY, du);
        axw(OFS_DEAD, {1'b0, dl});
        axw(OFS_CTRL, c);
        repeat (40) @(posedge clk);
        hi = 0;
        per = 0;
        n = 0;
        while (lvl(s, inv) !== 1'b0 && n < 100) begin @(negedge clk); n++; end
        while (lvl(s, inv) !== 1'b1 && n < 200) begin @(negedge clk); n++; end
        while (lvl(s, inv) === 1'b1 && n < 300) begin @(negedge clk); n++; hi++; per++; end
        while (lvl(s, inv) === 1'b0 && n < 400) begin @(negedge clk); n++; per++; end
        `CHK(per, 16)
    endtask : pwm_case
    task automatic t_regs();
        axr(OFS_CTRL);
        `CHK(d, 32'h0000_0000)
        axr(8'h40);
        `CHK(r, RESP_SLVERR)
        axw(8'h40, 8'h12);
        `CHK(r, RESP_SLVERR)
    endtask : t_regs
    task automatic t_compare();
        axw(OFS_TSEL, 8'h10);
        axw(OFS_DUTY, 8'h00);
        axw(OFS_SHADOW, 8'h01);
        axw(OFS_CTRL, {4'h0, MODE_CMP_TRIG});
        wait_evt(t0);
        `CHK({tmr_rst, adc, inhibit}, 4'b0111)
        wait_evt(t1);
        `CHK(t1 - t0, 258)
        `CHK(tmr_flag, 2'b00)
        axw(OFS_DUTY, 8'hF0);
        axw(OFS_CTRL, {4'h0, MODE_CMP_SWI});
        wait_evt(t0);
        `CHK({cmp_ev, tmr_rst, adc}, 4'b1000)
    endtask : t_compare
    task automatic t_pwm();
        axw(OFS_PERIOD, 8'h03);
        axw(OFS_TSEL, 8'h00);
        pwm_case(8'h2C, 8'h01, 7'h00, 0, 1'b0);
        `CHK(hi, 6)
        axw(OFS_SHADOW, 8'h55);
        axr(OFS_SHADOW);
        `CHK(d, 32'h0000_0001)
        pwm_case(8'h2F, 8'h01, 7'h00, 0, 1'b1);
        `CHK(hi, 6)
        pwm_case(8'hAC, 8'h01, 7'h00, 1, 1'b0);
        `CHK(hi, 10)
        pwm_case(8'hAC, 8'h01, 7'h01, 0, 1'b0);
        `CHK(hi inside {[2:5]}, 1'b1)
        pwm_case(8'h6C, 8'h01, 7'h00, 3, 1'b0);
        `CHK({hi[3:0], pins.a, pins.b, pins.c}, 7'b0110_100)
        pwm_case(8'hEC, 8'h01, 7'h00, 1, 1'b0);
        `CHK({hi[3:0], pins.a, pins.c, pins.d}, 7'b0110_010)
        axw(OFS_DUTY, 8'h10);
        axw(OFS_CTRL, 8'h0C);
        repeat (40) @(negedge clk);
        hi = 0;
        repeat (32) @(negedge clk) hi += int'(pins.a === 1'b1);
        `CHK(hi, 32)
        axw(OFS_DUTY, 8'h00);
        repeat (40) @(negedge clk);
        hi = 0;
        repeat (32) @(negedge clk) hi += int'(pins.a === 1'b1);
        `CHK(hi, 0)
    endtask : t_pwm
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        tally_and_finish();
    end
    initial begin
        req = '0;
        rst = 1'b1;
        cyc = 0;
        err_total = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_compare();
        t_pwm();
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
